// >>> verilog/exec_pkg.sv
// Shared types and constants of the arithmetic, multiply and branch executor.
package exec_pkg;

   // Datapath and register file dimensions.
   localparam int unsigned DATA_W   = 8;
   localparam int unsigned PC_W     = 16;
   localparam int unsigned REG_NUM  = 32;
   localparam int unsigned REG_IDX_W = 5;

   // Fixed register indices: product pair and indirect pointer pair.
   localparam logic [4:0] PROD_LO_IDX = 5'h00;
   localparam logic [4:0] PROD_HI_IDX = 5'h01;
   localparam logic [4:0] PTR_LO_IDX  = 5'h1e;
   localparam logic [4:0] PTR_HI_IDX  = 5'h1f;

   // Status flag bit positions.
   localparam int unsigned FLAG_C = 0;
   localparam int unsigned FLAG_Z = 1;
   localparam int unsigned FLAG_N = 2;
   localparam int unsigned FLAG_V = 3;
   localparam int unsigned FLAG_S = 4;
   localparam int unsigned FLAG_H = 5;
   localparam int unsigned FLAG_T = 6;
   localparam int unsigned FLAG_I = 7;

   // Cycle counts; the wait counter holds the cycles beyond the first.
   localparam logic [1:0] WAIT_NONE       = 2'h0;
   localparam logic [1:0] WAIT_WORD_OP    = 2'h1;
   localparam logic [1:0] WAIT_PRODUCT    = 2'h1;
   localparam logic [1:0] WAIT_PTR_JUMP   = 2'h1;
   localparam logic [1:0] WAIT_PTR_INVOKE = 2'h2;
   localparam logic [1:0] WAIT_BR_TAKEN   = 2'h1;
   localparam logic [1:0] WAIT_SKIP_SHORT = 2'h1;
   localparam logic [1:0] WAIT_SKIP_LONG  = 2'h2;

   // Program counter steps.
   localparam logic [15:0] PC_STEP       = 16'h0001;
   localparam logic [15:0] PC_SKIP_SHORT = 16'h0002;
   localparam logic [15:0] PC_SKIP_LONG  = 16'h0003;

   // Mask base for clearing bits.
   localparam logic [7:0] ALL_ONES = 8'hff;

   // APB map: one word per register, data in the low bits.
   localparam logic [11:0] ADDR_REGFILE = 12'h000;
   localparam logic [11:0] ADDR_REGLAST = 12'h07c;
   localparam logic [11:0] ADDR_SREG    = 12'h080;
   localparam logic [11:0] ADDR_PC      = 12'h084;
   localparam logic [11:0] ADDR_CTRL    = 12'h088;
   localparam logic [11:0] ADDR_STATUS  = 12'h08c;
   localparam int unsigned CTRL_RUN     = 0;
   localparam int unsigned STATUS_BUSY  = 0;
   localparam int unsigned STATUS_READY = 1;

   // Reset values.
   localparam logic [7:0]  SREG_RESET = 8'h00;
   localparam logic [15:0] PC_RESET   = 16'h0000;
   localparam logic        RUN_RESET  = 1'b0;

   // Decoded operations accepted on the issue port.
   typedef enum logic [4:0] {
      OP_NONE,
      OP_SUM,
      OP_SUM_CARRY,
      OP_WORD_IMMEDIATE_SUM,
      OP_WORD_IMMEDIATE_DIFFERENCE,
      OP_DIFFERENCE,
      OP_DIFFERENCE_WITH_BORROW,
      OP_CONJUNCTION,
      OP_DISJUNCTION,
      OP_EXCLUSIVE_DISJUNCTION,
      OP_CLEAR_BITS_MASK,
      OP_ZERO_MINUS_TEST,
      OP_UNSIGNED_PRODUCT,
      OP_SIGNED_PRODUCT,
      OP_MIXED_SIGN_PRODUCT,
      OP_FRACTIONAL_UNSIGNED_PRODUCT,
      OP_FRACTIONAL_SIGNED_PRODUCT,
      OP_FRACTIONAL_MIXED_PRODUCT,
      OP_POINTER_JUMP,
      OP_POINTER_SUBROUTINE_INVOKE,
      OP_COMPARE_SKIP_EQUAL,
      OP_COMPARE,
      OP_COMPARE_WITH_BORROW,
      OP_SKIP_REG_BIT_CLEAR,
      OP_SKIP_REG_BIT_SET,
      OP_SKIP_IO_BIT_CLEAR,
      OP_SKIP_IO_BIT_SET,
      OP_BRANCH_STATUS_SET,
      OP_BRANCH_STATUS_CLEAR,
      OP_BRANCH_SIGNED_GE,
      OP_BRANCH_SIGNED_LT
   } op_t;

   // One decoded instruction.
   typedef struct packed {
      op_t        op;
      logic [4:0] dst;
      logic [4:0] src;
      logic       use_imm;
      logic [7:0] imm;
      logic [2:0] bit_sel;
      logic [6:0] offset;
      logic       next_is_long;
      logic       io_bit;
   } issue_t;

   // Return address pushed by the pointer subroutine invoke.
   typedef struct packed {
      logic        valid;
      logic [15:0] addr;
   } push_t;

   // Result of an eight-bit add or subtract.
   typedef struct packed {
      logic [7:0] res;
      logic       h;
      logic       v;
      logic       c;
   } alu_t;

endpackage

// >>> verilog/alu_branch_execute.sv
// Executor for arithmetic, logic, multiply, compare, skip and branch work.
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
// Function
// - Add two registers, write sum, update Z C N V H, one cycle.
// - Add two registers plus carry, update Z C N V H, one cycle.
// - Add or subtract immediate on register pair, Z C N V S, two cycles.
// - Subtract register or constant, optional borrow, Z C N V H, one cycle.
// - AND, OR, XOR write destination, update only Z N V, one cycle.
// - Clear bits ANDs with 0xFF minus mask; set bits ORs mask.
// - Zero-or-minus test ANDs register with itself, Z N V, one cycle.
// - Integer multiplies put product in r1:r0, update Z C, two cycles.
// - Fractional multiplies shift product left once, Z C, two cycles.
// - Pointer jump loads PC from r31:r30, no flags, two cycles.
// - Pointer invoke pushes return address, loads PC, three cycles.
// - Compare-skip skips when equal; one, two or three cycles.
// - Compares subtract without storing, update Z N V C H, one cycle.
// - Register bit skips test a bit clear or set; one to three cycles.
// - I/O bit skips test a supplied bit clear or set; one to three cycles.
// - Status branches test any bit; PC plus offset plus one when taken.
// - Signed branches test N XOR V for zero or one.
// - Unsigned, equal and sign branches test C, Z and N.
// - Interrupt branches test the global enable flag.
// - Half-carry and T branches test their flags with branch timing.
// - Overflow and carry branches test V and C, one or two cycles.
module alu_branch_execute (
   input  wire logic             clk_sys_i,
   input  wire logic             resetn_i,
   input  wire logic             psel_i,
   input  wire logic             penable_i,
   input  wire logic             pwrite_i,
   input  wire logic [11:0]      paddr_i,
   input  wire logic [31:0]      pwdata_i,
   output logic      [31:0]      prdata_o,
   output logic                  pready_o,
   output logic                  pslverr_o,
   input  wire logic             issue_valid_i,
   input  wire exec_pkg::issue_t issue_i,
   output logic                  issue_ready_o,
   output logic      [15:0]      pc_o,
   output logic      [7:0]       sreg_o,
   output exec_pkg::push_t       push_o
);
   import exec_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // State.

   typedef struct packed {
      logic [31:0][7:0] rf;
      logic [7:0]       sreg;
      logic [15:0]      pc;
      logic [1:0]       wait_cnt;
      logic             run;
      push_t            push;
      logic [31:0]      rdata;
      logic             err;
   } state_t;

   state_t q;
   state_t next_q;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers.

   // Eight-bit add with carry in and its flags.
   function automatic alu_t add8(input logic [7:0] a,
                                 input logic [7:0] b,
                                 input logic       ci);
      logic [8:0] s;
      alu_t       r;
      s     = {1'b0, a} + {1'b0, b} + {8'h00, ci};
      r.res = s[7:0];
      r.c   = s[8];
      r.h   = (a[3] & b[3]) | (b[3] & ~s[3]) | (~s[3] & a[3]);
      r.v   = (a[7] & b[7] & ~s[7]) | (~a[7] & ~b[7] & s[7]);
      return r;
   endfunction

   // Eight-bit subtract with borrow in and its flags.
   function automatic alu_t sub8(input logic [7:0] a,
                                 input logic [7:0] b,
                                 input logic       ci);
      logic [8:0] s;
      alu_t       r;
      s     = {1'b0, a} - {1'b0, b} - {8'h00, ci};
      r.res = s[7:0];
      r.c   = (~a[7] & b[7]) | (b[7] & s[7]) | (s[7] & ~a[7]);
      r.h   = (~a[3] & b[3]) | (b[3] & s[3]) | (s[3] & ~a[3]);
      r.v   = (a[7] & ~b[7] & ~s[7]) | (~a[7] & b[7] & s[7]);
      return r;
   endfunction

   // Address decode shared by the read and write paths.
   function automatic logic in_regfile(input logic [11:0] a);
      return (a <= ADDR_REGLAST) && (a[1:0] == 2'b00);
   endfunction

   // Signed 9x9 product of two operands with optional sign extension.
   function automatic logic [15:0] product(input logic [7:0] a,
                                           input logic [7:0] b,
                                           input logic       sa,
                                           input logic       sb);
      logic signed [8:0]  ea;
      logic signed [8:0]  eb;
      logic signed [17:0] p;
      ea = signed'({sa & a[7], a});
      eb = signed'({sb & b[7], b});
      p  = ea * eb;
      return p[15:0];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Handshake outputs.

   // The bus answers without wait states in the access phase.
   assign pready_o      = penable_i;
   assign issue_ready_o = q.run && (q.wait_cnt == WAIT_NONE);
   assign prdata_o      = q.rdata;
   assign pslverr_o     = q.err & penable_i;
   assign pc_o          = q.pc;
   assign sreg_o        = q.sreg;
   assign push_o        = q.push;

   ////////////////////////////////////////////////////////////////////////////
   // Next state.

   always_comb begin
      logic [7:0]  a;
      logic [7:0]  b;
      logic [15:0] w;
      logic [15:0] wr;
      logic [15:0] p;
      logic [15:0] br;
      logic        cond;
      logic        skip;
      alu_t        r;
      logic        bus_ok;
      next_q            = q;
      next_q.push.valid = 1'b0;
      a                 = 8'h00;
      b                 = 8'h00;
      w                 = 16'h0000;
      wr                = 16'h0000;
      p                 = 16'h0000;
      br                = 16'h0000;
      cond              = 1'b0;
      skip              = 1'b0;
      r                 = '0;
      bus_ok            = in_regfile(paddr_i) || paddr_i == ADDR_SREG ||
                          paddr_i == ADDR_PC || paddr_i == ADDR_CTRL ||
                          paddr_i == ADDR_STATUS;

      // Count down the remaining cycles of a multi-cycle instruction.
      if (q.wait_cnt != WAIT_NONE) begin
         next_q.wait_cnt = q.wait_cnt - 2'h1;
      end

      // Setup phase: capture read data and the error answer.
      if (psel_i && !penable_i) begin
         next_q.err   = !bus_ok;
         next_q.rdata = 32'h0000_0000;
         if (in_regfile(paddr_i)) begin
            next_q.rdata = {24'h000000, q.rf[paddr_i[6:2]]};
         end else if (paddr_i == ADDR_SREG) begin
            next_q.rdata = {24'h000000, q.sreg};
         end else if (paddr_i == ADDR_PC) begin
            next_q.rdata = {16'h0000, q.pc};
         end else if (paddr_i == ADDR_CTRL) begin
            next_q.rdata = {31'h00000000, q.run};
         end else if (paddr_i == ADDR_STATUS) begin
            next_q.rdata = {30'h00000000, issue_ready_o,
                            q.wait_cnt != WAIT_NONE};
         end
      end

      // Access phase: writes take effect; execution below overrides.
      if (psel_i && penable_i && pwrite_i) begin
         if (in_regfile(paddr_i)) begin
            next_q.rf[paddr_i[6:2]] = pwdata_i[7:0];
         end else if (paddr_i == ADDR_SREG) begin
            next_q.sreg = pwdata_i[7:0];
         end else if (paddr_i == ADDR_PC) begin
            next_q.pc = pwdata_i[15:0];
         end else if (paddr_i == ADDR_CTRL) begin
            next_q.run = pwdata_i[CTRL_RUN];
         end
      end

      // Execute an accepted instruction.
      if (issue_valid_i && issue_ready_o) begin
         a  = q.rf[issue_i.dst];
         b  = issue_i.use_imm ? issue_i.imm : q.rf[issue_i.src];
         w  = {q.rf[issue_i.dst + 5'h01], q.rf[issue_i.dst]};
         br = q.pc + {{9{issue_i.offset[6]}}, issue_i.offset} + PC_STEP;
         next_q.pc = q.pc + PC_STEP;
         case (issue_i.op)
            OP_SUM, OP_SUM_CARRY: begin
               r = add8(a, b, issue_i.op == OP_SUM_CARRY &&
                              q.sreg[FLAG_C]);
               next_q.rf[issue_i.dst]  = r.res;
               next_q.sreg[FLAG_Z]     = r.res == 8'h00;
               next_q.sreg[FLAG_C]     = r.c;
               next_q.sreg[FLAG_N]     = r.res[7];
               next_q.sreg[FLAG_V]     = r.v;
               next_q.sreg[FLAG_H]     = r.h;
            end
            OP_WORD_IMMEDIATE_SUM, OP_WORD_IMMEDIATE_DIFFERENCE: begin
               if (issue_i.op == OP_WORD_IMMEDIATE_SUM) begin
                  wr = w + {10'h000, issue_i.imm[5:0]};
                  next_q.sreg[FLAG_V] = ~w[15] & wr[15];
                  next_q.sreg[FLAG_C] = w[15] & ~wr[15];
               end else begin
                  wr = w - {10'h000, issue_i.imm[5:0]};
                  next_q.sreg[FLAG_V] = w[15] & ~wr[15];
                  next_q.sreg[FLAG_C] = ~w[15] & wr[15];
               end
               next_q.rf[issue_i.dst]         = wr[7:0];
               next_q.rf[issue_i.dst + 5'h01] = wr[15:8];
               next_q.sreg[FLAG_Z] = wr == 16'h0000;
               next_q.sreg[FLAG_N] = wr[15];
               next_q.sreg[FLAG_S] = wr[15] ^ next_q.sreg[FLAG_V];
               next_q.wait_cnt     = WAIT_WORD_OP;
            end
            OP_DIFFERENCE, OP_DIFFERENCE_WITH_BORROW,
            OP_COMPARE, OP_COMPARE_WITH_BORROW: begin
               cond = (issue_i.op == OP_DIFFERENCE_WITH_BORROW ||
                       issue_i.op == OP_COMPARE_WITH_BORROW);
               r = sub8(a, b, cond && q.sreg[FLAG_C]);
               if (issue_i.op == OP_DIFFERENCE ||
                   issue_i.op == OP_DIFFERENCE_WITH_BORROW) begin
                  next_q.rf[issue_i.dst] = r.res;
               end
               // Borrow forms chain zero across bytes of a wider number.
               next_q.sreg[FLAG_Z] = (r.res == 8'h00) &&
                                     (!cond || q.sreg[FLAG_Z]);
               next_q.sreg[FLAG_C] = r.c;
               next_q.sreg[FLAG_N] = r.res[7];
               next_q.sreg[FLAG_V] = r.v;
               next_q.sreg[FLAG_H] = r.h;
            end
            OP_CONJUNCTION, OP_DISJUNCTION, OP_EXCLUSIVE_DISJUNCTION,
            OP_CLEAR_BITS_MASK, OP_ZERO_MINUS_TEST: begin
               case (issue_i.op)
                  OP_CONJUNCTION:     r.res = a & b;
                  OP_DISJUNCTION:     r.res = a | b;
                  OP_CLEAR_BITS_MASK: r.res = a & (ALL_ONES - b);
                  OP_ZERO_MINUS_TEST: r.res = a & a;
                  default:            r.res = a ^ b;
               endcase
               next_q.rf[issue_i.dst] = r.res;
               next_q.sreg[FLAG_Z]    = r.res == 8'h00;
               next_q.sreg[FLAG_N]    = r.res[7];
               next_q.sreg[FLAG_V]    = 1'b0;
            end
            OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT,
            OP_FRACTIONAL_UNSIGNED_PRODUCT, OP_FRACTIONAL_SIGNED_PRODUCT,
            OP_FRACTIONAL_MIXED_PRODUCT: begin
               b = q.rf[issue_i.src];
               p = product(a, b,
                  issue_i.op == OP_SIGNED_PRODUCT ||
                  issue_i.op == OP_MIXED_SIGN_PRODUCT ||
                  issue_i.op == OP_FRACTIONAL_SIGNED_PRODUCT ||
                  issue_i.op == OP_FRACTIONAL_MIXED_PRODUCT,
                  issue_i.op == OP_SIGNED_PRODUCT ||
                  issue_i.op == OP_FRACTIONAL_SIGNED_PRODUCT);
               next_q.sreg[FLAG_C] = p[15];
               if (issue_i.op == OP_FRACTIONAL_UNSIGNED_PRODUCT ||
                   issue_i.op == OP_FRACTIONAL_SIGNED_PRODUCT ||
                   issue_i.op == OP_FRACTIONAL_MIXED_PRODUCT) begin
                  p = {p[14:0], 1'b0};
               end
               next_q.rf[PROD_LO_IDX] = p[7:0];
               next_q.rf[PROD_HI_IDX] = p[15:8];
               next_q.sreg[FLAG_Z]    = p == 16'h0000;
               next_q.wait_cnt        = WAIT_PRODUCT;
            end
            OP_POINTER_JUMP: begin
               next_q.pc       = {q.rf[PTR_HI_IDX], q.rf[PTR_LO_IDX]};
               next_q.wait_cnt = WAIT_PTR_JUMP;
            end
            OP_POINTER_SUBROUTINE_INVOKE: begin
               next_q.push.valid = 1'b1;
               next_q.push.addr  = q.pc + PC_STEP;
               next_q.pc         = {q.rf[PTR_HI_IDX], q.rf[PTR_LO_IDX]};
               next_q.wait_cnt   = WAIT_PTR_INVOKE;
            end
            OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR,
            OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR,
            OP_SKIP_IO_BIT_SET: begin
               case (issue_i.op)
                  OP_COMPARE_SKIP_EQUAL:
                     skip = a == q.rf[issue_i.src];
                  OP_SKIP_REG_BIT_CLEAR:
                     skip = !q.rf[issue_i.src][issue_i.bit_sel];
                  OP_SKIP_REG_BIT_SET:
                     skip = q.rf[issue_i.src][issue_i.bit_sel];
                  OP_SKIP_IO_BIT_CLEAR:
                     skip = !issue_i.io_bit;
                  default:
                     skip = issue_i.io_bit;
               endcase
               if (skip) begin
                  next_q.pc = q.pc + (issue_i.next_is_long ?
                                      PC_SKIP_LONG : PC_SKIP_SHORT);
                  next_q.wait_cnt = issue_i.next_is_long ?
                                    WAIT_SKIP_LONG : WAIT_SKIP_SHORT;
               end
            end
            OP_BRANCH_STATUS_SET, OP_BRANCH_STATUS_CLEAR,
            OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT: begin
               // Any flag, including C, Z, N, V, H, T and I, by index.
               case (issue_i.op)
                  OP_BRANCH_STATUS_SET:
                     cond = q.sreg[issue_i.bit_sel];
                  OP_BRANCH_STATUS_CLEAR:
                     cond = !q.sreg[issue_i.bit_sel];
                  OP_BRANCH_SIGNED_GE:
                     cond = !(q.sreg[FLAG_N] ^ q.sreg[FLAG_V]);
                  default:
                     cond = q.sreg[FLAG_N] ^ q.sreg[FLAG_V];
               endcase
               if (cond) begin
                  next_q.pc       = br;
                  next_q.wait_cnt = WAIT_BR_TAKEN;
               end
            end
            default: begin
               next_q.pc = q.pc + PC_STEP;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register.

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         q          <= '0;
         q.sreg     <= SREG_RESET;
         q.pc       <= PC_RESET;
         q.run      <= RUN_RESET;
         q.wait_cnt <= WAIT_NONE;
      end else begin
         q <= next_q;
      end
   end

endmodule

// >>> tb/exec_monitor.sv
// Checker of issue timing, flag retention and program counter moves.
`timescale 1ns/1ps
module exec_monitor
   import exec_pkg::*;
(
   input wire logic             clk_sys_i,
   input wire logic             resetn_i,
   input wire logic             issue_valid_i,
   input wire exec_pkg::issue_t issue_i,
   input wire logic             issue_ready_o,
   input wire logic [15:0]      pc_o,
   input wire logic [7:0]       sreg_o,
   input wire exec_pkg::push_t  push_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   logic        acc;
   logic [15:0] tgt;
   // Accepted instruction and its relative branch target.
   assign acc = issue_valid_i && issue_ready_o;
   assign tgt = pc_o + {{9{issue_i.offset[6]}}, issue_i.offset} + 16'h0001;
   //////////////////////////////////////////////////////////////////////////
   property p_sum;
      acc && issue_i.op == OP_SUM
         |=> issue_ready_o && pc_o == $past(pc_o) + 16'h0001;
   endproperty
   a_sum: assert property (p_sum)
      else $error("sum is not a single cycle step");
   property p_word;
      acc && issue_i.op inside {OP_WORD_IMMEDIATE_SUM,
         OP_WORD_IMMEDIATE_DIFFERENCE} |=> !issue_ready_o ##1 issue_ready_o;
   endproperty
   a_word: assert property (p_word)
      else $error("word operation does not take two cycles");
   property p_prod;
      acc && issue_i.op inside {[OP_UNSIGNED_PRODUCT:
         OP_FRACTIONAL_MIXED_PRODUCT]} |=> !issue_ready_o ##1 issue_ready_o;
   endproperty
   a_prod: assert property (p_prod)
      else $error("product does not take two cycles");
   property p_logic;
      acc && issue_i.op inside {[OP_CONJUNCTION:
         OP_ZERO_MINUS_TEST]} |=> !sreg_o[FLAG_V]
         && sreg_o[7:4] == $past(sreg_o[7:4]) && $stable(sreg_o[FLAG_C]);
   endproperty
   a_logic: assert property (p_logic)
      else $error("logic operation touched a foreign flag");
   property p_jump;
      acc && issue_i.op == OP_POINTER_JUMP
         |=> $stable(sreg_o) && !issue_ready_o ##1 issue_ready_o;
   endproperty
   a_jump: assert property (p_jump)
      else $error("pointer jump timing or flags wrong");
   property p_call;
      acc && issue_i.op == OP_POINTER_SUBROUTINE_INVOKE
         |=> push_o.valid && push_o.addr == $past(pc_o) + 16'h0001
         && !issue_ready_o ##1 !push_o.valid && !issue_ready_o
         ##1 issue_ready_o;
   endproperty
   a_call: assert property (p_call)
      else $error("pointer invoke push or timing wrong");
   property p_brset;
      acc && issue_i.op == OP_BRANCH_STATUS_SET && sreg_o[issue_i.bit_sel]
         |=> pc_o == $past(tgt) && !issue_ready_o ##1 issue_ready_o;
   endproperty
   a_brset: assert property (p_brset)
      else $error("taken status branch target or timing wrong");
   property p_ge;
      acc && issue_i.op == OP_BRANCH_SIGNED_GE
         && (sreg_o[FLAG_N] ^ sreg_o[FLAG_V])
         |=> issue_ready_o && pc_o == $past(pc_o) + 16'h0001;
   endproperty
   a_ge: assert property (p_ge)
      else $error("signed branch taken on negative result");
   property p_io;
      acc && issue_i.op == OP_SKIP_IO_BIT_SET && issue_i.io_bit
         && issue_i.next_is_long |=> pc_o == $past(pc_o) + 16'h0003
         && !issue_ready_o ##1 !issue_ready_o ##1 issue_ready_o;
   endproperty
   a_io: assert property (p_io)
      else $error("long skip step or timing wrong");
endmodule

// >>> tb/tb_top.sv
// Self-checking testbench of the executor over its bus and issue port.
`timescale 1ns/1ps
module tb_top;
   import exec_pkg::*;
   logic        clk_sys_i = 1'b0;
   logic        resetn_i = 1'b0;
   logic        psel_i = 1'b0;
   logic        penable_i = 1'b0;
   logic        pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0;
   logic [31:0] prdata_o, rd;
   logic        pready_o, pslverr_o, issue_ready_o, er;
   logic        issue_valid_i = 1'b0;
   issue_t      issue_i = '0;
   logic [15:0] pc_o, pcx;
   logic [7:0]  sreg_o, s;
   push_t       push_o;
   logic [16:0] pe [6];
   int          failures = 0;
   int          num_checks = 0;
   // Clock at 25 MHz.
   always #20 clk_sys_i = ~clk_sys_i;
   alu_branch_execute dut (.*);
   //////////////////////////////////////////////////////////////////////////
   // Verdict and end of run.
   task automatic end_of_test;
      if (failures == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic lim(input int n);
      if (n >= 40) begin
         failures++;
         end_of_test();
      end
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("Error %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // Bus transfer: setup, then access held until ready is sampled.
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      do @(posedge clk_sys_i); while (pready_o !== 1'b1 && ++n < 40);
      lim(n);
      er = pslverr_o;
      rd = prdata_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic wr(input logic [4:0] r, input logic [7:0] v);
      apb(1'b1, {5'h00, r, 2'b00}, {24'h0, v});
   endtask
   task automatic rr(input logic [4:0] r, input logic [7:0] e);
      apb(1'b0, {5'h00, r, 2'b00}, 32'h0);
      chk(rd, {24'h0, e});
   endtask
   // Offer one instruction and hold it until it is accepted.
   task automatic ex(input op_t o, input logic [4:0] d, input logic [4:0] r,
                     input logic u, input logic [7:0] k, input logic [2:0] b,
                     input logic [6:0] f, input logic [1:0] x);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      pcx = pc_o;
      issue_i <= '{o, d, r, u, k, b, f, x[1], x[0]};
      issue_valid_i <= 1'b1;
      do @(posedge clk_sys_i); while (issue_ready_o !== 1'b1 && ++n < 40);
      lim(n);
      issue_valid_i <= 1'b0;
      @(negedge clk_sys_i);
   endtask
   //////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      pe = '{17'h001fe, 17'h1fffe, 17'h1fffe, 17'h003fc, 17'h1fffc,
             17'h1fffc};
      repeat (5) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h100, 32'h0);
      chk({31'h0, er}, 32'h1);
      apb(1'b1, ADDR_CTRL, 32'h1);
      wr(5'd2, 8'h7f);
      wr(5'd3, 8'h01);
      ex(OP_SUM, 5'd2, 5'd3, 1'b0, 8'h00, 3'h0, 7'h00, 2'b00);
      rr(5'd2, 8'h80);
      chk(sreg_o, 8'h2c);
      apb(1'b1, ADDR_SREG, 32'h01);
      wr(5'd4, 8'hff);
      ex(OP_SUM_CARRY, 5'd4, 5'd5, 1'b0, 8'h00, 3'h0, 7'h00, 2'b00);
      chk(sreg_o, 8'h23);
      wr(5'd24, 8'hff);
      wr(5'd25, 8'h7f);
      ex(OP_WORD_IMMEDIATE_SUM, 5'd24, 5'd0, 1'b1, 8'h01, 3'h0, 7'h00,
         2'b00);
      rr(5'd25, 8'h80);
      chk(sreg_o, 8'h2c);
      apb(1'b1, ADDR_SREG, 32'h03);
      wr(5'd6, 8'h10);
      ex(OP_DIFFERENCE_WITH_BORROW, 5'd6, 5'd0, 1'b1, 8'h0f, 3'h0, 7'h00,
         2'b00);
      rr(5'd6, 8'h00);
      chk(sreg_o, 8'h22);
      apb(1'b1, ADDR_SREG, 32'hc1);
      wr(5'd7, 8'hf0);
      ex(OP_CLEAR_BITS_MASK, 5'd7, 5'd0, 1'b1, 8'h30, 3'h0, 7'h00, 2'b00);
      rr(5'd7, 8'hc0);
      chk(sreg_o, 8'hc5);
      ex(OP_ZERO_MINUS_TEST, 5'd8, 5'd8, 1'b0, 8'h00, 3'h0, 7'h00, 2'b00);
      chk(sreg_o, 8'hc3);
      // Every product form on minus one by two.
      wr(5'd16, 8'hff);
      wr(5'd17, 8'h02);
      for (int i = 0; i < 6; i++) begin
         ex(op_t'(int'(OP_UNSIGNED_PRODUCT) + i), 5'd16, 5'd17, 1'b0,
            8'h00, 3'h0, 7'h00, 2'b00);
         rr(5'd0, pe[i][7:0]);
         rr(5'd1, pe[i][15:8]);
         chk(sreg_o[1:0], {31'h0, pe[i][16]});
      end
      wr(5'd30, 8'h34);
      wr(5'd31, 8'h12);
      ex(OP_POINTER_JUMP, 5'd0, 5'd0, 1'b0, 8'h00, 3'h0, 7'h00, 2'b00);
      chk(pc_o, 16'h1234);
      wr(5'd30, 8'h00);
      wr(5'd31, 8'h20);
      ex(OP_POINTER_SUBROUTINE_INVOKE, 5'd0, 5'd0, 1'b0, 8'h00, 3'h0,
         7'h00, 2'b00);
      chk(pc_o, 16'h2000);
      // Status branches on every flag bit, both senses.
      s = 8'h55;
      apb(1'b1, ADDR_SREG, {24'h0, s});
      for (int b = 0; b < 8; b++) begin
         ex(OP_BRANCH_STATUS_SET, 5'd0, 5'd0, 1'b0, 8'h00, b[2:0], 7'h7d,
            2'b00);
         chk(pc_o, 16'(pcx + (s[b] ? 16'hfffe : 16'h0001)));
         ex(OP_BRANCH_STATUS_CLEAR, 5'd0, 5'd0, 1'b0, 8'h00, b[2:0], 7'h05,
            2'b00);
         chk(pc_o, pcx + (s[b] ? 16'h0001 : 16'h0006));
      end
      // Signed branches with equal and unequal sign and overflow.
      for (int j = 0; j < 2; j++) begin
         s = (j == 0) ? 8'h0c : 8'h04;
         apb(1'b1, ADDR_SREG, {24'h0, s});
         ex(OP_BRANCH_SIGNED_GE, 5'd0, 5'd0, 1'b0, 8'h00, 3'h0, 7'h02, 2'b00);
         chk(pc_o, pcx + ((j == 0) ? 16'h0003 : 16'h0001));
         ex(OP_BRANCH_SIGNED_LT, 5'd0, 5'd0, 1'b0, 8'h00, 3'h0, 7'h02, 2'b00);
         chk(pc_o, pcx + ((j == 0) ? 16'h0001 : 16'h0003));
      end
      ex(OP_SKIP_IO_BIT_SET, 5'd0, 5'd0, 1'b0, 8'h00, 3'h0, 7'h00, 2'b11);
      chk(pc_o, pcx + 16'h0003);
      ex(OP_SKIP_IO_BIT_CLEAR, 5'd0, 5'd0, 1'b0, 8'h00, 3'h0, 7'h00, 2'b01);
      chk(pc_o, pcx + 16'h0001);
      ex(OP_SKIP_REG_BIT_SET, 5'd7, 5'd7, 1'b0, 8'h00, 3'h6, 7'h00, 2'b00);
      chk(pc_o, pcx + 16'h0002);
      ex(OP_SKIP_REG_BIT_CLEAR, 5'd7, 5'd7, 1'b0, 8'h00, 3'h5, 7'h00, 2'b10);
      chk(pc_o, pcx + 16'h0003);
      ex(OP_COMPARE_SKIP_EQUAL, 5'd16, 5'd16, 1'b0, 8'h00, 3'h0, 7'h00,
         2'b00);
      chk(pc_o, pcx + 16'h0002);
      apb(1'b1, ADDR_SREG, 32'hc0);
      ex(OP_COMPARE, 5'd2, 5'd0, 1'b1, 8'h01, 3'h0, 7'h00, 2'b00);
      chk(sreg_o, 8'he8);
      rr(5'd2, 8'h80);
      ex(OP_EXCLUSIVE_DISJUNCTION, 5'd7, 5'd7, 1'b0, 8'h0, 3'h0, 7'h0, 2'b0);
      chk(sreg_o, 8'he2);
      end_of_test();
   end
endmodule
bind alu_branch_execute exec_monitor mon (.clk_sys_i, .resetn_i,
   .issue_valid_i, .issue_i, .issue_ready_o, .pc_o, .sreg_o, .push_o);
